/* include/fpac_pkg.sv */
package fpac_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int unsigned SECTOR_COUNT     = 16;
  localparam int unsigned SECTOR_BYTES     = 1024;
  localparam int unsigned EE_BYTES         = 1024;
  localparam int unsigned EE_SECTOR_BYTES  = 256;
  localparam int unsigned EE_SECTOR_COUNT  = EE_BYTES / EE_SECTOR_BYTES;

  // ****************************************
  // Timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_PS    = 25000;
  localparam int unsigned ERASE_TIME_US    = 3000;
  localparam int unsigned PROG_TIME_NS     = 30000;
  // Run times sit well inside the limits, so launch latency never reaches them
  localparam int unsigned ERASE_RUN_US     = 2000;
  localparam int unsigned PROG_RUN_NS      = 20000;
  localparam int unsigned ERASE_LIMIT      = (ERASE_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int unsigned PROG_LIMIT       = PROG_TIME_NS / (CLK_PERIOD_PS / 1000);
  localparam int unsigned ERASE_CYCLES     = (ERASE_RUN_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int unsigned PROG_CYCLES      = PROG_RUN_NS / (CLK_PERIOD_PS / 1000);

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL          = 8'h00;
  localparam logic [7:0] OFS_PAGE          = 8'h04;
  localparam logic [7:0] OFS_OFFSET        = 8'h08;
  localparam logic [7:0] OFS_DATA          = 8'h0C;
  localparam logic [7:0] OFS_TYPE          = 8'h10;
  localparam logic [7:0] OFS_GUARD         = 8'h14;
  localparam logic [7:0] OFS_STATUS        = 8'h18;
  localparam logic [7:0] OFS_PROT0         = 8'h1C;
  localparam logic [7:0] OFS_PROT1         = 8'h20;
  localparam logic [7:0] OFS_EXEC          = 8'h24;

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int unsigned CTRL_GO_BIT      = 0;
  localparam int unsigned CTRL_ICP_BIT     = 1;
  localparam int unsigned CTRL_EE_BIT      = 2;
  localparam int unsigned PAGE_SECT_LSB    = 2;
  localparam logic [7:0]  TYPE_SECT_ERASE  = 8'hE6;
  localparam logic [7:0]  TYPE_PROGRAM     = 8'h6E;
  localparam logic [7:0]  TYPE_MASS_ERASE  = 8'hA5;
  localparam logic [7:0]  TYPE_READ        = 8'h5A;
  localparam logic [3:0]  GUARD_OK         = 4'h5;
  localparam logic [7:0]  ERASED_BYTE      = 8'hFF;
  localparam logic [15:0] PROT_RESET       = 16'h0000;

  typedef enum logic [1:0] {
    FPAC_OK,
    FPAC_REFUSED,
    FPAC_GUARD_ABORT,
    FPAC_NOT_ERASED
  } fpac_result_type;

  typedef struct packed {
    logic        in_circuit_programming;
    logic        ee;
    logic [7:0]  kind;
    logic [3:0]  sector;
    logic [9:0]  offset;
    logic [7:0]  wdata;
  } fpac_req_type;

endpackage : fpac_pkg

/* rtl/fpac_timer.sv */
`timescale 1ns/100ps
module fpac_timer (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        start,
  input  wire logic [16:0] cycles,
  output logic             done
);

  logic [16:0] count;
  logic        run;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 17'h00000;
      run   <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= cycles;
        run   <= 1'b1;
      end else if (run) begin
        if (count <= 17'h00001) begin
          run  <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - 17'h00001;
        end
      end
    end
  end

endmodule : fpac_timer

/* rtl/fpac_ctrl.sv */
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/100ps
module fpac_ctrl (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        icp_mode,
  output logic             busy,
  output logic             refused
);

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0]  flash_mem [fpac_pkg::SECTOR_COUNT*fpac_pkg::SECTOR_BYTES];
  logic [7:0]  ee_mem    [fpac_pkg::EE_BYTES];
  logic [fpac_pkg::SECTOR_COUNT-1:0] prot0;
  logic [fpac_pkg::SECTOR_COUNT-1:0] prot1;
  logic [15:0] option_id;

  // ****************************************
  // Registers
  // ****************************************
  logic [5:0]  page;
  logic [7:0]  offset_lo;
  logic [7:0]  wdata;
  logic [7:0]  kind;
  logic [3:0]  guard;
  logic [3:0]  exec_sector;
  logic        ctrl_icp;
  logic        ctrl_ee;
  logic [7:0]  rdata;
  fpac_pkg::fpac_result_type result;

  logic        access;
  logic        wr_ok;
  logic        ctrl_wr;
  logic        go;
  fpac_pkg::fpac_req_type req;
  logic        allowed;
  logic        timer_start;
  logic [16:0] timer_cycles;
  logic        timer_done;
  logic [13:0] faddr;
  logic [9:0]  eaddr;
  logic        pend_erase;
  logic        pend_prog;
  logic        pend_mass;

  assign access = psel && penable;
  assign wr_ok  = access && pwrite;
  assign ctrl_wr = wr_ok && paddr == fpac_pkg::OFS_CTRL;
  assign go     = ctrl_wr && pwdata[fpac_pkg::CTRL_GO_BIT] && !busy;

  // Mode bits written together with go apply to that same command
  always_comb begin
    req.in_circuit_programming    = (ctrl_wr ? pwdata[fpac_pkg::CTRL_ICP_BIT] : ctrl_icp) && icp_mode;
    req.ee     = ctrl_wr ? pwdata[fpac_pkg::CTRL_EE_BIT] : ctrl_ee;
    req.kind   = kind;
    req.sector = page[5:fpac_pkg::PAGE_SECT_LSB];
    req.offset = req.ee ? {page[1:0], offset_lo} : {page[1:0], offset_lo};
    req.wdata  = wdata;
  end

  // ****************************************
  // Permission check
  // ****************************************
  always_comb begin
    allowed = 1'b0;
    if (req.kind == fpac_pkg::TYPE_MASS_ERASE) begin
      allowed = req.in_circuit_programming;
    end else if (req.ee) begin
      allowed = 1'b1;
    end else if (req.in_circuit_programming) begin
      allowed = !prot0[req.sector];
    end else begin
      allowed = !prot1[req.sector] || req.sector == exec_sector;
    end
    if (req.kind != fpac_pkg::TYPE_SECT_ERASE && req.kind != fpac_pkg::TYPE_PROGRAM
        && req.kind != fpac_pkg::TYPE_MASS_ERASE && req.kind != fpac_pkg::TYPE_READ) begin
      allowed = 1'b0;
    end
  end

  assign faddr = {req.sector, req.offset};
  assign eaddr = {page[1:0], offset_lo};

  always_comb begin
    timer_cycles = 17'(fpac_pkg::PROG_CYCLES);
    if (req.kind != fpac_pkg::TYPE_PROGRAM) begin
      timer_cycles = 17'(fpac_pkg::ERASE_CYCLES);
    end
  end

  // ****************************************
  // Operation launch and completion
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy        <= 1'b0;
      refused     <= 1'b0;
      result      <= fpac_pkg::FPAC_OK;
      timer_start <= 1'b0;
      pend_erase  <= 1'b0;
      pend_prog   <= 1'b0;
      pend_mass   <= 1'b0;
      rdata       <= 8'h00;
    end else begin
      timer_start <= 1'b0;
      if (go) begin
        refused <= 1'b0;
        if (!req.in_circuit_programming && guard != fpac_pkg::GUARD_OK) begin
          result  <= fpac_pkg::FPAC_GUARD_ABORT;
          refused <= 1'b1;
        end else if (!allowed) begin
          result  <= fpac_pkg::FPAC_REFUSED;
          refused <= 1'b1;
        end else if (req.kind == fpac_pkg::TYPE_READ) begin
          rdata  <= req.ee ? ee_mem[eaddr] : flash_mem[faddr];
          result <= fpac_pkg::FPAC_OK;
        end else if (req.kind == fpac_pkg::TYPE_PROGRAM && !req.ee
                     && flash_mem[faddr] != fpac_pkg::ERASED_BYTE) begin
          result  <= fpac_pkg::FPAC_NOT_ERASED;
          refused <= 1'b1;
        end else begin
          busy        <= 1'b1;
          timer_start <= 1'b1;
          result      <= fpac_pkg::FPAC_OK;
          pend_erase  <= req.kind == fpac_pkg::TYPE_SECT_ERASE;
          pend_prog   <= req.kind == fpac_pkg::TYPE_PROGRAM;
          pend_mass   <= req.kind == fpac_pkg::TYPE_MASS_ERASE;
        end
      end else if (timer_done) begin
        busy       <= 1'b0;
        pend_erase <= 1'b0;
        pend_prog  <= 1'b0;
        pend_mass  <= 1'b0;
      end
    end
  end

  fpac_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (timer_start),
    .cycles  (timer_cycles),
    .done    (timer_done)
  );

  // Memory changes only at completion, never partially
  always_ff @(posedge pclk) begin
    if (timer_done && pend_mass) begin
      for (int i = 0; i < fpac_pkg::SECTOR_COUNT*fpac_pkg::SECTOR_BYTES; i++) begin
        flash_mem[i] <= fpac_pkg::ERASED_BYTE;
      end
    end else if (timer_done && pend_erase && !ctrl_ee) begin
      for (int i = 0; i < fpac_pkg::SECTOR_BYTES; i++) begin
        flash_mem[{req.sector, 10'(i)}] <= fpac_pkg::ERASED_BYTE;
      end
    end else if (timer_done && pend_prog && !ctrl_ee) begin
      flash_mem[faddr] <= wdata;
    end
  end

  always_ff @(posedge pclk) begin
    if (timer_done && pend_erase && ctrl_ee) begin
      for (int i = 0; i < fpac_pkg::EE_SECTOR_BYTES; i++) begin
        ee_mem[{page[1:0], 8'(i)}] <= fpac_pkg::ERASED_BYTE;
      end
    end else if (timer_done && pend_prog && ctrl_ee) begin
      ee_mem[eaddr] <= wdata;
    end
  end

  // ****************************************
  // Protection bits and option/ID word
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot0     <= fpac_pkg::PROT_RESET;
      prot1     <= fpac_pkg::PROT_RESET;
      option_id <= 16'h0000;
    end else if (timer_done && pend_mass) begin
      prot0     <= fpac_pkg::PROT_RESET;
      prot1     <= fpac_pkg::PROT_RESET;
      option_id <= 16'hFFFF;
    end else if (wr_ok && icp_mode && !busy) begin
      if (paddr == fpac_pkg::OFS_PROT0) prot0 <= pwdata[15:0] | prot0;
      if (paddr == fpac_pkg::OFS_PROT1) prot1 <= pwdata[15:0] | prot1;
    end
  end

  // ****************************************
  // APB register writes
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page        <= 6'h00;
      offset_lo   <= 8'h00;
      wdata       <= 8'h00;
      kind        <= 8'h00;
      guard       <= 4'h0;
      exec_sector <= 4'h0;
      ctrl_icp    <= 1'b0;
      ctrl_ee     <= 1'b0;
    end else if (wr_ok && !busy) begin
      unique case (paddr)
        fpac_pkg::OFS_CTRL: begin
          ctrl_icp <= pwdata[fpac_pkg::CTRL_ICP_BIT];
          ctrl_ee  <= pwdata[fpac_pkg::CTRL_EE_BIT];
        end
        fpac_pkg::OFS_PAGE:   page        <= pwdata[5:0];
        fpac_pkg::OFS_OFFSET: offset_lo   <= pwdata[7:0];
        fpac_pkg::OFS_DATA:   wdata       <= pwdata[7:0];
        fpac_pkg::OFS_TYPE:   kind        <= pwdata[7:0];
        fpac_pkg::OFS_GUARD:  guard       <= pwdata[3:0];
        fpac_pkg::OFS_EXEC:   exec_sector <= pwdata[3:0];
        default: begin
        end
      endcase
    end
  end

  // ****************************************
  // APB read and answer
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
      if (psel && !penable) begin
        unique case (paddr)
          fpac_pkg::OFS_CTRL:   prdata <= {29'h0, ctrl_ee, ctrl_icp, busy};
          fpac_pkg::OFS_PAGE:   prdata <= {26'h0, page};
          fpac_pkg::OFS_OFFSET: prdata <= {24'h0, offset_lo};
          fpac_pkg::OFS_DATA:   prdata <= {24'h0, rdata};
          fpac_pkg::OFS_TYPE:   prdata <= {24'h0, kind};
          fpac_pkg::OFS_GUARD:  prdata <= {28'h0, guard};
          fpac_pkg::OFS_STATUS: prdata <= {28'h0, refused, busy, result};
          fpac_pkg::OFS_PROT0:  prdata <= {16'h0, prot0};
          fpac_pkg::OFS_PROT1:  prdata <= {16'h0, prot1};
          fpac_pkg::OFS_EXEC:   prdata <= {28'h0, exec_sector};
          default:              pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  guard_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && !req.in_circuit_programming && guard != fpac_pkg::GUARD_OK |=> refused && !busy)
    else $error("guard mismatch not aborted");
  mass_icp_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && kind == fpac_pkg::TYPE_MASS_ERASE && !req.in_circuit_programming |=> !busy)
    else $error("mass erase accepted from user code");
  prot0_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && req.in_circuit_programming && !req.ee && prot0[req.sector]
    && kind != fpac_pkg::TYPE_MASS_ERASE |=> refused)
    else $error("programmer access to protected sector");
  prot1_block_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && !req.in_circuit_programming && !req.ee && guard == fpac_pkg::GUARD_OK
    && prot1[req.sector] && req.sector != exec_sector |=> refused)
    else $error("user access to protected sector");
  ee_open_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && req.ee && (req.in_circuit_programming || guard == fpac_pkg::GUARD_OK)
    && (kind == fpac_pkg::TYPE_PROGRAM || kind == fpac_pkg::TYPE_READ
        || kind == fpac_pkg::TYPE_SECT_ERASE) |=> result != fpac_pkg::FPAC_REFUSED)
    else $error("data area access refused");
  mass_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    timer_done && pend_mass |=> prot0 == 16'h0000 && prot1 == 16'h0000)
    else $error("mass erase left protection set");
  refuse_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
    go && !allowed |=> !busy && !timer_start)
    else $error("refused operation started");
  prot_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !icp_mode && !(timer_done && pend_mass) |=> $stable(prot0) && $stable(prot1))
    else $error("protection changed outside programming");

endmodule : fpac_ctrl

/* testbench/fpac_host_model.sv */
`timescale 1ns/100ps
module fpac_host_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  output logic             icp_mode
);
  initial begin
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0000_0000;
    icp_mode = 1'b0;
  end

  // ****************************************
  // Bus cycle
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data must never look like the last word
    pwdata  <= ~d;
  endtask : apb

  // Pin waveform is decoded outside; only the level reaches the block
  task automatic enter_icp(input logic on);
    @(posedge pclk);
    icp_mode <= on;
  endtask : enter_icp
endmodule : fpac_host_model

/* testbench/tb.sv */
`timescale 1ns/100ps
module tb;
  typedef struct packed {
    logic        chk;
    logic [31:0] data;
    logic        err;
  } fpac_note_type;

  logic          pclk;
  logic          presetn;
  logic          psel;
  logic          penable;
  logic          pwrite;
  logic [7:0]    paddr;
  logic [31:0]   pwdata;
  logic [31:0]   prdata;
  logic          pready;
  logic          pslverr;
  logic          icp_mode;
  logic          busy;
  logic          refused;
  fpac_note_type notes[$];
  fpac_note_type note;
  logic [31:0]   seed = 32'h0000_0035;
  logic [31:0]   a;
  logic [31:0]   g;
  logic [7:0]    b;
  int            num_errors = 0;
  int            cmp_count = 0;
  int            cycles = 0;

  fpac_ctrl i_fpac_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .icp_mode(icp_mode), .busy(busy), .refused(refused));
  fpac_host_model i_fpac_host_model (.pclk(pclk), .prdata(prdata), .pready(pready),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .icp_mode(icp_mode));

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", name, e, s);
    end
  endtask : check

  task automatic summarize();
    $display("Comparisons %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d,
                      input logic chk, input logic [31:0] e, input logic err);
    logic [31:0] r;
    notes.push_back('{chk, e, err});
    i_fpac_host_model.apb(w, ad, d, r);
  endtask : xfer

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    xfer(1'b1, ad, d, 1'b0, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    xfer(1'b0, ad, 32'h0, 1'b1, e, 1'b0);
  endtask : rd

  task automatic target(input logic [3:0] s, input logic [9:0] o);
    wr(fpac_pkg::OFS_PAGE, {26'h0, s, o[9:8]});
    wr(fpac_pkg::OFS_OFFSET, {24'h0, o[7:0]});
  endtask : target

  // Start a command, poll until idle, then check the outcome
  task automatic run(input logic in_circuit_programming, input logic ee, input logic [7:0] kind,
                     input fpac_pkg::fpac_result_type res);
    logic [31:0] r;
    int          n;
    int          t0;
    int          lim;
    lim = (kind == fpac_pkg::TYPE_PROGRAM) ? fpac_pkg::PROG_LIMIT : fpac_pkg::ERASE_LIMIT;
    wr(fpac_pkg::OFS_TYPE, {24'h0, kind});
    t0 = cycles;
    wr(fpac_pkg::OFS_CTRL, {29'h0, ee, in_circuit_programming, 1'b1});
    r = 32'h0000_0004;
    n = 0;
    while (r[2] !== 1'b0 && n < 200000) begin
      notes.push_back('{1'b0, 32'h0, 1'b0});
      i_fpac_host_model.apb(1'b0, fpac_pkg::OFS_STATUS, 32'h0, r);
      n++;
    end
    check("duration", 32'h1, {31'h0, (cycles - t0) < lim});
    check("busy", 32'h0, {31'h0, busy});
    check("refused", {31'h0, res != fpac_pkg::FPAC_OK}, {31'h0, refused});
    rd(fpac_pkg::OFS_STATUS, {28'h0, res != fpac_pkg::FPAC_OK, 1'b0, res});
  endtask : run

  // ****************************************
  // Clock, timeout and monitor
  // ****************************************
  always #12.5 pclk = ~pclk;

  // Mass erase alone takes 80000 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 100000) begin
      num_errors++;
      summarize();
    end
  end

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      note = notes.pop_front();
      check("pslverr", {31'h0, note.err}, {31'h0, pslverr});
      if (note.chk) begin
        check("prdata", note.data, prdata);
      end
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    pclk    = 1'b0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(fpac_pkg::OFS_PROT0, 32'h0);
    rd(fpac_pkg::OFS_PROT1, 32'h0);
    xfer(1'b0, 8'h40, 32'h0, 1'b0, 32'h0, 1'b1);
    i_fpac_host_model.enter_icp(1'b1);
    wr(fpac_pkg::OFS_PROT0, 32'h0000_FFFF);
    rd(fpac_pkg::OFS_PROT0, 32'h0000_FFFF);
    wr(fpac_pkg::OFS_GUARD, 32'h0000_0005);
    run(1'b0, 1'b0, fpac_pkg::TYPE_MASS_ERASE, fpac_pkg::FPAC_REFUSED);
    run(1'b1, 1'b0, fpac_pkg::TYPE_MASS_ERASE, fpac_pkg::FPAC_OK);
    rd(fpac_pkg::OFS_PROT0, 32'h0);
    a = rnd();
    b = 8'(rnd()) & 8'h7F;
    target(4'h3, a[9:0]);
    wr(fpac_pkg::OFS_DATA, {24'h0, b});
    run(1'b1, 1'b0, fpac_pkg::TYPE_PROGRAM, fpac_pkg::FPAC_OK);
    run(1'b1, 1'b0, fpac_pkg::TYPE_READ, fpac_pkg::FPAC_OK);
    rd(fpac_pkg::OFS_DATA, {24'h0, b});
    run(1'b1, 1'b0, fpac_pkg::TYPE_PROGRAM, fpac_pkg::FPAC_NOT_ERASED);
    wr(fpac_pkg::OFS_PROT0, 32'h0000_0008);
    run(1'b1, 1'b0, fpac_pkg::TYPE_READ, fpac_pkg::FPAC_REFUSED);
    run(1'b1, 1'b0, fpac_pkg::TYPE_SECT_ERASE, fpac_pkg::FPAC_REFUSED);
    target(4'h5, a[9:0]);
    for (int i = 0; i < 3; i++) begin
      g = rnd();
      if (g[3:0] == 4'h5) begin
        g[3:0] = 4'h6;
      end
      wr(fpac_pkg::OFS_GUARD, {28'h0, g[3:0]});
      run(1'b0, 1'b0, fpac_pkg::TYPE_PROGRAM, fpac_pkg::FPAC_GUARD_ABORT);
    end
    wr(fpac_pkg::OFS_GUARD, 32'h0000_0005);
    run(1'b0, 1'b0, fpac_pkg::TYPE_PROGRAM, fpac_pkg::FPAC_OK);
    run(1'b0, 1'b0, fpac_pkg::TYPE_READ, fpac_pkg::FPAC_OK);
    rd(fpac_pkg::OFS_DATA, {24'h0, b});
    wr(fpac_pkg::OFS_PROT1, 32'h0000_0018);
    wr(fpac_pkg::OFS_EXEC, 32'h0000_0003);
    target(4'h3, a[9:0]);
    run(1'b0, 1'b0, fpac_pkg::TYPE_READ, fpac_pkg::FPAC_OK);
    rd(fpac_pkg::OFS_DATA, {24'h0, b});
    target(4'h4, a[9:0]);
    run(1'b0, 1'b0, fpac_pkg::TYPE_PROGRAM, fpac_pkg::FPAC_REFUSED);
    run(1'b0, 1'b0, fpac_pkg::TYPE_SECT_ERASE, fpac_pkg::FPAC_REFUSED);
    b = 8'(rnd());
    target(4'h0, {2'h2, a[7:0]});
    wr(fpac_pkg::OFS_DATA, {24'h0, b});
    run(1'b0, 1'b1, fpac_pkg::TYPE_PROGRAM, fpac_pkg::FPAC_OK);
    run(1'b1, 1'b1, fpac_pkg::TYPE_READ, fpac_pkg::FPAC_OK);
    rd(fpac_pkg::OFS_DATA, {24'h0, b});
    i_fpac_host_model.enter_icp(1'b0);
    wr(fpac_pkg::OFS_PROT1, 32'h0000_FFFF);
    rd(fpac_pkg::OFS_PROT1, 32'h0000_0018);
    repeat (2) @(posedge pclk);
    summarize();
  end
endmodule : tb
